// ===== shift_irq_pkg.sv
// Constants, mode codes and state type of the serial shift and interrupt unit.
// Assumes one phase-two clock domain; offsets are the 4-bit register select codes.
package shift_irq_pkg;
	localparam int BYTE_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int FLAG_W = 7;
	localparam logic [3:0] OFS_T2_LATCH = 4'h8;
	localparam logic [3:0] OFS_SR = 4'ha;
	localparam logic [3:0] OFS_ACR = 4'hb;
	localparam logic [3:0] OFS_PCR = 4'hc;
	localparam logic [3:0] OFS_IFR = 4'hd;
	localparam logic [3:0] OFS_IER = 4'he;
	localparam int MODE_LO = 2;
	localparam int MODE_HI = 4;
	localparam int SHIFT_FLAG = 2;
	localparam int TOP_BIT = 7;
	localparam logic [2:0] MODE_OFF = 3'h0;
	localparam logic [2:0] MODE_IN_T2 = 3'h1;
	localparam logic [2:0] MODE_IN_PHI2 = 3'h2;
	localparam logic [2:0] MODE_IN_EXT = 3'h3;
	localparam logic [2:0] MODE_OUT_FREE = 3'h4;
	localparam logic [2:0] MODE_OUT_T2 = 3'h5;
	localparam logic [2:0] MODE_OUT_PHI2 = 3'h6;
	localparam logic [2:0] MODE_OUT_EXT = 3'h7;
	localparam logic [8:0] T2_EXTRA = 9'h002;
	localparam logic [8:0] PHI2_HALF = 9'h001;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int PCR_DAT_HI = 7;
	localparam int PCR_DAT_LO = 6;
	localparam int PCR_DAT_LEVEL = 5;
	localparam logic [1:0] PCR_DAT_MANUAL = 2'h3;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [6:0] RESET_FLAGS = 7'h00;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} shift_state_t;
endpackage

// ===== pin_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk_sys_in; only the second stage is used.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_sys_in, // Phase-two clock
	input wire logic nrst_in, // Async reset, active low
	input wire logic [WIDTH-1:0] pins_in, // Raw pin levels
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_t;
	sync_t r, n;

	always_comb begin
		n.stage1 = pins_in;
		n.stage2 = r.stage1;
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign sync_out = r.stage2;
endmodule
`default_nettype wire

// ===== byte_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; in_ready is low while full, out_valid low while empty.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk_sys_in, // Phase-two clock
	input wire logic nrst_in, // Async reset, active low
	input wire logic in_valid_in, // Push request
	output logic in_ready_out, // Room for a word
	input wire logic [WIDTH-1:0] in_data_in, // Word pushed
	output logic out_valid_out, // Word available
	input wire logic out_ready_in, // Pop request
	output logic [WIDTH-1:0] out_data_out // Oldest word
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0] count;
	} fifo_t;
	fifo_t r, n;
	logic push, pop;

	always_comb begin
		n = r;
		push = in_valid_in && (r.count != (PW+1)'(DEPTH));
		pop = out_ready_in && (r.count != '0);
		if (push) begin
			n.mem[r.wr_ptr] = in_data_in;
			n.wr_ptr = (r.wr_ptr == PW'(DEPTH - 1)) ? '0 : r.wr_ptr + 1'b1;
		end
		if (pop) begin
			n.rd_ptr = (r.rd_ptr == PW'(DEPTH - 1)) ? '0 : r.rd_ptr + 1'b1;
		end
		n.count = r.count + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign in_ready_out = (r.count != (PW+1)'(DEPTH));
	assign out_valid_out = (r.count != '0);
	assign out_data_out = r.mem[r.rd_ptr];
endmodule
`default_nettype wire

// ===== serial_shift_and_irq_unit.sv
// Serial shift unit with its shift interrupt flag, flag and enable registers.
// Assumes clk_sys_in is the phase-two clock and each cycle with select high is one access.
// What this block does
// - Mode field in auxiliary control bits 2-4
// - Mode 000 disables shifter, data pin follows PERIPHERAL_CONTROL_REG, clock pin released
// - Flag bit 2 signals byte needed/available
// - Shift register read or write clears flag
// - Timer input mode clock period 2(n+2)
// - Timer input captures after rise, flag after 8
// - Phase-two input clock divided by 2, 8 pulses
// - External input samples after rising edge, 8 pulses
// - Free-running output repeats byte, no interrupt
// - Timer output sends byte, flag after 8
// - Phase-two output divided by 2, flag after 8
// - External output drives bit after falling edge
// - Flag bit 7 shows any flag set
// - Interrupt low when enabled flag set
// - Writing one to a flag clears it
// - Enable write with bit 7 high sets bits
// - Enable write with bit 7 low clears bits
// - Enable readback has bit 7 as one
`timescale 1ns/1ps
`default_nettype none
module serial_shift_and_irq_unit #(
	parameter int FIFO_DEPTH = shift_irq_pkg::FIFO_DEPTH
) (
	input wire logic clk_sys_in, // Phase-two clock, 40 MHz
	input wire logic nrst_in, // Async reset, active low
	input wire logic cs_in, // Register access this cycle
	input wire logic rw_in, // 1 read, 0 write
	input wire logic [3:0] rs_in, // Register select
	input wire logic [7:0] data_in, // Write data
	output logic [7:0] rd_data_out, // Read data, cycle after access
	output logic rd_oe_out, // Read data valid
	input wire logic [6:0] other_flags_set_in, // Set pulses for other flags
	output logic interrupt_out_n_out, // Interrupt, active low
	input wire logic serial_clock_pin_in, // Clock pin level
	output logic serial_clock_pin_out, // Clock pin drive
	output logic serial_clock_pin_oe_out, // Clock pin enable
	input wire logic serial_data_pin_in, // Data pin level
	output logic serial_data_pin_out, // Data pin drive
	output logic serial_data_pin_oe_out // Data pin enable
);
	typedef struct packed {
		shift_irq_pkg::shift_state_t st;
		logic [7:0] auxiliary_control_reg;
		logic [7:0] peripheral_control_reg;
		logic [7:0] t2_latch;
		logic [7:0] shreg;
		logic [6:0] flags;
		logic [6:0] en;
		logic [3:0] bits;
		logic [8:0] div;
		logic sclk;
		logic sclk_oe;
		logic sdat;
		logic sdat_oe;
		logic [1:0] cap_pend;
		logic ext_prev;
		logic push;
		logic rd_oe;
		logic [7:0] rd_data;
		logic irq_n;
	} state_t;

	localparam state_t RESET_STATE = '{
		st: shift_irq_pkg::ST_IDLE,
		auxiliary_control_reg: shift_irq_pkg::RESET_BYTE,
		peripheral_control_reg: shift_irq_pkg::RESET_BYTE,
		t2_latch: shift_irq_pkg::RESET_BYTE,
		shreg: shift_irq_pkg::RESET_BYTE,
		flags: shift_irq_pkg::RESET_FLAGS,
		en: shift_irq_pkg::RESET_FLAGS,
		bits: '0,
		div: '0,
		sclk: 1'b1,
		sclk_oe: 1'b0,
		sdat: 1'b1,
		sdat_oe: 1'b0,
		cap_pend: 2'b00,
		ext_prev: 1'b1,
		push: 1'b0,
		rd_oe: 1'b0,
		rd_data: shift_irq_pkg::RESET_BYTE,
		irq_n: 1'b1
	};

	function automatic logic mode_is_input(input logic [2:0] m);
		return (m == shift_irq_pkg::MODE_IN_T2) || (m == shift_irq_pkg::MODE_IN_PHI2)
			|| (m == shift_irq_pkg::MODE_IN_EXT);
	endfunction

	function automatic logic mode_is_ext(input logic [2:0] m);
		return (m == shift_irq_pkg::MODE_IN_EXT) || (m == shift_irq_pkg::MODE_OUT_EXT);
	endfunction

	function automatic logic [8:0] half_period(input logic [2:0] m, input logic [7:0] latch);
		if ((m == shift_irq_pkg::MODE_IN_PHI2) || (m == shift_irq_pkg::MODE_OUT_PHI2)) begin
			return shift_irq_pkg::PHI2_HALF;
		end
		return {1'b0, latch} + shift_irq_pkg::T2_EXTRA;
	endfunction

	state_t r, n;
	logic [1:0] pins_sync;
	logic clk_s, dat_s;
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [7:0] fifo_out_data;
	logic [2:0] mode;
	logic acc, wr, rd, sr_acc, start_req, do_start, rise, fall, shift_set;
	logic [6:0] flag_clr, flag_set;

	// Pins cross into the phase-two domain before any logic sees them
	pin_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.pins_in({serial_clock_pin_in, serial_data_pin_in}),
		.sync_out(pins_sync)
	);
	assign clk_s = pins_sync[1];
	assign dat_s = pins_sync[0];

	// Received bytes queue here so a slow host does not lose input
	byte_fifo #(
		.WIDTH(shift_irq_pkg::BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_sys_in(clk_sys_in),
		.nrst_in(nrst_in),
		.in_valid_in(r.push),
		.in_ready_out(fifo_in_ready),
		.in_data_in(r.shreg),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_out_data)
	);

	always_comb begin
		n = r;
		n.push = 1'b0;
		n.rd_oe = 1'b0;
		n.ext_prev = clk_s;
		mode = r.auxiliary_control_reg[shift_irq_pkg::MODE_HI:shift_irq_pkg::MODE_LO];
		acc = cs_in;
		wr = acc && !rw_in;
		rd = acc && rw_in;
		sr_acc = acc && (rs_in == shift_irq_pkg::OFS_SR);
		fifo_pop = sr_acc && rw_in && fifo_out_valid;
		flag_clr = '0;
		flag_set = other_flags_set_in;
		shift_set = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		do_start = 1'b0;

		if (wr) begin
			unique case (rs_in)
				shift_irq_pkg::OFS_T2_LATCH: n.t2_latch = data_in;
				shift_irq_pkg::OFS_SR: n.shreg = data_in;
				shift_irq_pkg::OFS_ACR: n.auxiliary_control_reg = data_in;
				shift_irq_pkg::OFS_PCR: n.peripheral_control_reg = data_in;
				shift_irq_pkg::OFS_IFR: flag_clr = data_in[6:0];
				shift_irq_pkg::OFS_IER: begin
					if (data_in[shift_irq_pkg::TOP_BIT]) begin
						n.en = r.en | data_in[6:0];
					end else begin
						n.en = r.en & ~data_in[6:0];
					end
				end
				default: ;
			endcase
		end

		if (rd) begin
			n.rd_oe = 1'b1;
			unique case (rs_in)
				shift_irq_pkg::OFS_SR: n.rd_data = fifo_out_valid ? fifo_out_data : r.shreg;
				shift_irq_pkg::OFS_ACR: n.rd_data = r.auxiliary_control_reg;
				shift_irq_pkg::OFS_PCR: n.rd_data = r.peripheral_control_reg;
				shift_irq_pkg::OFS_IFR: n.rd_data = {|r.flags, r.flags};
				shift_irq_pkg::OFS_IER: n.rd_data = {1'b1, r.en};
				default: n.rd_data = '0;
			endcase
		end

		if (sr_acc) begin
			flag_clr[shift_irq_pkg::SHIFT_FLAG] = 1'b1;
		end

		// Input modes start on read or write, output modes on write only
		start_req = sr_acc && (mode != shift_irq_pkg::MODE_OFF) && (mode_is_input(mode) || !rw_in);

		unique case (r.st)
			shift_irq_pkg::ST_IDLE: begin
				if (start_req) begin
					do_start = 1'b1;
				end
			end
			shift_irq_pkg::ST_WAIT: begin
				do_start = 1'b1;
			end
			shift_irq_pkg::ST_RUN: begin
				if (mode_is_ext(mode)) begin
					rise = clk_s && !r.ext_prev;
					fall = !clk_s && r.ext_prev;
				end else if (r.bits != shift_irq_pkg::BITS_PER_BYTE) begin
					if (r.div <= shift_irq_pkg::PHI2_HALF) begin
						n.div = half_period(mode, r.t2_latch);
						n.sclk = !r.sclk;
						rise = !r.sclk;
						fall = r.sclk;
					end else begin
						n.div = r.div - 9'h001;
					end
				end
				if (mode_is_input(mode)) begin
					// Internal clocks wait out the synchroniser so the pin level at the rise is taken
					if (mode_is_ext(mode) ? rise : r.cap_pend[1]) begin
						n.shreg = {r.shreg[6:0], dat_s};
						if (r.bits == shift_irq_pkg::BITS_PER_BYTE - 4'h1 && mode_is_ext(mode)) begin
							n.bits = shift_irq_pkg::BITS_PER_BYTE;
						end
					end
					n.cap_pend = {r.cap_pend[0], rise && !mode_is_ext(mode)};
					if (rise && !mode_is_ext(mode)) begin
						n.bits = r.bits + 4'h1;
					end
					if ((mode_is_ext(mode) && rise && r.bits == shift_irq_pkg::BITS_PER_BYTE - 4'h1)
						|| (r.cap_pend[1] && r.bits == shift_irq_pkg::BITS_PER_BYTE)) begin
						n.st = shift_irq_pkg::ST_IDLE;
						n.push = 1'b1;
						shift_set = 1'b1;
					end else if (mode_is_ext(mode) && rise) begin
						n.bits = r.bits + 4'h1;
					end
				end else begin
					if (fall) begin
						// Rotate so free-running repeats the same byte
						n.sdat = r.shreg[7];
						n.shreg = {r.shreg[6:0], r.shreg[7]};
					end
					if (rise) begin
						if (r.bits == shift_irq_pkg::BITS_PER_BYTE - 4'h1) begin
							if (mode == shift_irq_pkg::MODE_OUT_FREE) begin
								n.bits = '0;
							end else begin
								n.bits = shift_irq_pkg::BITS_PER_BYTE;
								n.st = shift_irq_pkg::ST_IDLE;
								shift_set = 1'b1;
							end
						end else begin
							n.bits = r.bits + 4'h1;
						end
					end
				end
			end
		endcase

		if (do_start) begin
			// A full queue holds the start so no received byte is dropped
			if (mode_is_input(mode) && !fifo_in_ready) begin
				n.st = shift_irq_pkg::ST_WAIT;
			end else begin
				n.st = shift_irq_pkg::ST_RUN;
				n.bits = '0;
				n.div = half_period(mode, r.t2_latch);
				n.sclk = 1'b1;
				n.cap_pend = 2'b00;
			end
		end

		if (n.auxiliary_control_reg[shift_irq_pkg::MODE_HI:shift_irq_pkg::MODE_LO] == shift_irq_pkg::MODE_OFF) begin
			n.st = shift_irq_pkg::ST_IDLE;
			n.sclk = 1'b1;
		end

		// A set in the same cycle as a clear wins
		flag_set[shift_irq_pkg::SHIFT_FLAG] = shift_set;
		n.flags = (r.flags & ~flag_clr) | flag_set;
		if (n.auxiliary_control_reg[shift_irq_pkg::MODE_HI:shift_irq_pkg::MODE_LO] == shift_irq_pkg::MODE_OFF) begin
			n.flags[shift_irq_pkg::SHIFT_FLAG] = 1'b0;
		end
		n.irq_n = !(|(n.flags & n.en));

		unique case (n.auxiliary_control_reg[shift_irq_pkg::MODE_HI:shift_irq_pkg::MODE_LO])
			shift_irq_pkg::MODE_OFF: begin
				n.sclk_oe = 1'b0;
				n.sdat_oe = (n.peripheral_control_reg[shift_irq_pkg::PCR_DAT_HI:shift_irq_pkg::PCR_DAT_LO]
					== shift_irq_pkg::PCR_DAT_MANUAL);
				n.sdat = n.peripheral_control_reg[shift_irq_pkg::PCR_DAT_LEVEL];
			end
			shift_irq_pkg::MODE_IN_EXT: begin
				n.sclk_oe = 1'b0;
				n.sdat_oe = 1'b0;
			end
			shift_irq_pkg::MODE_OUT_EXT: begin
				n.sclk_oe = 1'b0;
				n.sdat_oe = 1'b1;
			end
			shift_irq_pkg::MODE_IN_T2, shift_irq_pkg::MODE_IN_PHI2: begin
				n.sclk_oe = 1'b1;
				n.sdat_oe = 1'b0;
			end
			shift_irq_pkg::MODE_OUT_FREE, shift_irq_pkg::MODE_OUT_T2, shift_irq_pkg::MODE_OUT_PHI2: begin
				n.sclk_oe = 1'b1;
				n.sdat_oe = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			r <= RESET_STATE;
		end else begin
			r <= n;
		end
	end

	assign rd_data_out = r.rd_data;
	assign rd_oe_out = r.rd_oe;
	assign interrupt_out_n_out = r.irq_n;
	assign serial_clock_pin_out = r.sclk;
	assign serial_clock_pin_oe_out = r.sclk_oe;
	assign serial_data_pin_out = r.sdat;
	assign serial_data_pin_oe_out = r.sdat_oe;
endmodule
`default_nettype wire

// ===== serial_shift_and_irq_unit_asserts.sv
// Checker for the serial shift and interrupt unit, bound to its top module.
// Assumes one clock; mode, timer latch and sent byte are tracked from host writes.
`timescale 1ns/1ps
`default_nettype none
module serial_shift_and_irq_unit_asserts #(
	parameter int FIFO_DEPTH = 8
) (
	input wire logic clk_sys_in, // Clock
	input wire logic nrst_in, // Reset
	input wire logic cs_in, // Select
	input wire logic rw_in, // Read
	input wire logic [3:0] rs_in, // Register
	input wire logic [7:0] data_in, // Write data
	input wire logic [7:0] rd_data_out, // Read data
	input wire logic rd_oe_out, // Read valid
	input wire logic [6:0] other_flags_set_in, // Flag sets
	input wire logic interrupt_out_n_out, // Interrupt
	input wire logic serial_clock_pin_in, // Clock pin
	input wire logic serial_clock_pin_out, // Clock drive
	input wire logic serial_clock_pin_oe_out, // Clock enable
	input wire logic serial_data_pin_in, // Data pin
	input wire logic serial_data_pin_out, // Data drive
	input wire logic serial_data_pin_oe_out // Data enable
);
	logic [2:0] mode_r;
	logic [7:0] n_r;
	logic [7:0] byte_r;
	logic [9:0] low_r;
	logic [3:0] rise_r;
	logic clk_q;
	wire logic wr = cs_in && !rw_in;
	wire logic rd = cs_in && rw_in;
	wire logic rise = serial_clock_pin_out && !clk_q && serial_clock_pin_oe_out;
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode_r <= 3'h0;
			n_r <= 8'h00;
			byte_r <= 8'h00;
			low_r <= 10'h000;
			rise_r <= 4'h0;
			clk_q <= 1'b1;
		end else begin
			if (wr && rs_in == shift_irq_pkg::OFS_ACR) mode_r <= data_in[4:2];
			if (wr && rs_in == shift_irq_pkg::OFS_T2_LATCH) n_r <= data_in;
			if (wr && rs_in == shift_irq_pkg::OFS_SR) byte_r <= data_in;
			low_r <= serial_clock_pin_out ? 10'h000 : low_r + 10'h001;
			clk_q <= serial_clock_pin_out;
			// Output modes restart only on writes
			if (cs_in && rs_in == shift_irq_pkg::OFS_SR && (!rw_in || !mode_r[2])) rise_r <= 4'h0;
			else if (rise) rise_r <= rise_r + 4'h1;
		end
	end
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!nrst_in);
	property p_off_idle;
		(mode_r == shift_irq_pkg::MODE_OFF) [*3] |-> !serial_clock_pin_oe_out;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("clock pin driven in mode off");
	property p_half;
		(mode_r[1:0] == 2'h2) && serial_clock_pin_oe_out && $fell(serial_clock_pin_out) |=> serial_clock_pin_out;
	endproperty
	a_half: assert property (p_half) else $error("divided clock low too long");
	property p_t2_low;
		rise && (mode_r == 3'h1 || mode_r == 3'h4 || mode_r == 3'h5) |-> low_r == {2'h0, n_r} + 10'h002;
	endproperty
	a_t2_low: assert property (p_t2_low) else $error("timer clock half period wrong");
	property p_eight;
		rise && mode_r != shift_irq_pkg::MODE_OUT_FREE |-> rise_r < 4'h8;
	endproperty
	a_eight: assert property (p_eight) else $error("more than eight clock pulses");
	property p_msb;
		rise && mode_r[2] && mode_r[1:0] != 2'h3 && rise_r < 4'h8 |-> serial_data_pin_out == byte_r[3'h7 - rise_r[2:0]];
	endproperty
	a_msb: assert property (p_msb) else $error("sent bit out of order");
	property p_rd_flags;
		rd && rs_in == shift_irq_pkg::OFS_IFR |=> rd_oe_out && rd_data_out[7] == |rd_data_out[6:0];
	endproperty
	a_rd_flags: assert property (p_rd_flags) else $error("flag summary bit wrong");
	property p_rd_en;
		rd && rs_in == shift_irq_pkg::OFS_IER |=> rd_oe_out && rd_data_out[7];
	endproperty
	a_rd_en: assert property (p_rd_en) else $error("enable top bit not one");
	property p_w1c;
		wr && rs_in == shift_irq_pkg::OFS_IFR && data_in == 8'h7f && mode_r == 3'h0 && other_flags_set_in == 7'h00
			##1 !cs_in && other_flags_set_in == 7'h00
			##1 rd && rs_in == shift_irq_pkg::OFS_IFR && other_flags_set_in == 7'h00 |=> rd_data_out == 8'h00;
	endproperty
	a_w1c: assert property (p_w1c) else $error("flags not cleared by write");
	property p_en_clr;
		wr && rs_in == shift_irq_pkg::OFS_IER && data_in == 8'h7f ##1 !cs_in ##1 rd && rs_in == shift_irq_pkg::OFS_IER
			|=> rd_data_out == 8'h80;
	endproperty
	a_en_clr: assert property (p_en_clr) else $error("enables not cleared");
	property p_irq_off;
		wr && rs_in == shift_irq_pkg::OFS_IER && data_in == 8'h7f |=> interrupt_out_n_out;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("interrupt with all disabled");
	c_eighth: cover property (rise && rise_r == 4'h7);
	c_sr_read: cover property (rd && rs_in == shift_irq_pkg::OFS_SR);
	c_irq: cover property (!interrupt_out_n_out);
endmodule
bind serial_shift_and_irq_unit serial_shift_and_irq_unit_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) serial_shift_and_irq_unit_asserts_i (
	.clk_sys_in, .nrst_in, .cs_in, .rw_in, .rs_in, .data_in, .rd_data_out, .rd_oe_out, .other_flags_set_in,
	.interrupt_out_n_out, .serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_out,
	.serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe_out);
`default_nettype wire

// ===== serial_peer_model.sv
// Behavioural serial peripheral on the clock and data pins.
// Assumes pull-ups on both pins; drives data only while talk_in is high.
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model #(
	parameter int HALF = 150
) (
	input wire logic go_in, // Start eight own clocks
	input wire logic clr_in, // Restart bit count
	input wire logic talk_in, // Drive data pin
	input wire logic [7:0] tx_in, // Byte to send
	input wire logic clk_pin_in, // Clock pin level
	input wire logic data_pin_in, // Data pin level
	output logic clk_out, // Clock drive
	output logic clk_oe_out, // Clock enable
	output logic data_out, // Data drive
	output logic data_oe_out, // Data enable
	output logic [7:0] rx_out // Bits seen at rises
);
	logic [3:0] cnt = 4'h0;
	initial begin
		clk_out = 1'b1;
		clk_oe_out = 1'b0;
		rx_out = 8'h00;
	end
	assign data_oe_out = talk_in;
	always @(posedge clk_pin_in or posedge clr_in) begin
		if (clr_in) cnt <= 4'h0;
		else begin
			cnt <= cnt + 4'h1;
			rx_out <= {rx_out[6:0], data_pin_in};
		end
	end
	// Bit moves at a clock fall or when clr_in falls with the clock idle high, so it stands at each rise
	always @(negedge clk_pin_in or negedge clr_in) data_out <= tx_in[3'h7 - cnt[2:0]];
	always @(posedge go_in) begin
		clk_oe_out = 1'b1;
		repeat (8) begin
			clk_out = 1'b0;
			#HALF clk_out = 1'b1;
			#HALF;
		end
		clk_oe_out = 1'b0;
	end
endmodule
`default_nettype wire

// ===== serial_shift_and_irq_unit_tb.sv
// Self-checking bench for the serial shift and interrupt unit.
// Assumes pull-ups on both serial pins and the peer model on the far side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s exp %h seen %h", n, e, g); end end
module serial_shift_and_irq_unit_tb;
	typedef struct packed {
		logic [2:0] mode;
		logic [7:0] n;
		logic [7:0] b;
		logic [7:0] exp_b;
	} row_t;
	row_t rows[6] = '{'{3'h1, 8'h03, 8'ha5, 8'ha5}, '{3'h2, 8'h00, 8'h3c, 8'h3c}, '{3'h3, 8'h00, 8'h81, 8'h81},
		'{3'h5, 8'h00, 8'h96, 8'h96}, '{3'h6, 8'h00, 8'h5a, 8'h5a}, '{3'h7, 8'h00, 8'hc3, 8'hc3}};
	logic clk_sys_in = 1'b0;
	logic nrst_in = 1'b0;
	logic cs_in = 1'b0;
	logic rw_in = 1'b0;
	logic [3:0] rs_in = 4'h0;
	logic [7:0] data_in = 8'h00;
	logic [6:0] other_flags_set_in = 7'h00;
	logic [7:0] rd_data_out, q, p_rx;
	logic rd_oe_out, interrupt_out_n_out, serial_clock_pin_out, serial_clock_pin_oe_out;
	logic serial_data_pin_out, serial_data_pin_oe_out, p_ck, p_ck_oe, p_dt, p_dt_oe;
	logic go = 1'b0;
	logic talk = 1'b0;
	logic clr = 1'b0;
	logic [7:0] tx = 8'h00;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	wire logic serial_clock_pin_in = serial_clock_pin_oe_out ? serial_clock_pin_out : p_ck_oe ? p_ck : 1'b1;
	wire logic serial_data_pin_in = serial_data_pin_oe_out ? serial_data_pin_out : p_dt_oe ? p_dt : 1'b1;
	serial_shift_and_irq_unit #(.FIFO_DEPTH(8)) serial_shift_and_irq_unit_i (.clk_sys_in, .nrst_in, .cs_in,
		.rw_in, .rs_in, .data_in, .rd_data_out, .rd_oe_out, .other_flags_set_in, .interrupt_out_n_out,
		.serial_clock_pin_in, .serial_clock_pin_out, .serial_clock_pin_oe_out, .serial_data_pin_in,
		.serial_data_pin_out, .serial_data_pin_oe_out);
	serial_peer_model serial_peer_model_i (.go_in(go), .clr_in(clr), .talk_in(talk), .tx_in(tx),
		.clk_pin_in(serial_clock_pin_in), .data_pin_in(serial_data_pin_in), .clk_out(p_ck), .clk_oe_out(p_ck_oe),
		.data_out(p_dt), .data_oe_out(p_dt_oe), .rx_out(p_rx));
	initial begin
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic acc(input logic r, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		cs_in <= 1'b1;
		rw_in <= r;
		rs_in <= a;
		data_in <= d;
		@(posedge clk_sys_in);
		cs_in <= 1'b0;
		#1 q = rd_data_out;
		if (r) `CHK("read strobe", 1'b1, rd_oe_out)
	endtask
	task automatic peer_set(input logic [7:0] b, input logic drive);
		@(posedge clk_sys_in);
		tx <= b;
		talk <= drive;
		clr <= 1'b1;
		@(posedge clk_sys_in);
		clr <= 1'b0;
	endtask
	task automatic peer_go();
		@(posedge clk_sys_in);
		go <= 1'b1;
		@(posedge clk_sys_in);
		go <= 1'b0;
	endtask
	task automatic wait_flag();
		q = 8'h00;
		for (int i = 0; i < 400 && !q[2]; i++) acc(1'b1, 4'hd, 8'h00);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_in);
		nrst_in <= 1'b1;
		acc(1'b1, 4'he, 8'h00);
		`CHK("enables", 8'h80, q)
		`CHK("pins idle", 3'h1, {serial_clock_pin_oe_out, serial_data_pin_oe_out, interrupt_out_n_out})
		$display("reset test done");
		acc(1'b0, 4'he, 8'h85);
		acc(1'b1, 4'he, 8'h00);
		`CHK("enables set", 8'h85, q)
		acc(1'b0, 4'he, 8'h7f);
		acc(1'b1, 4'he, 8'h00);
		`CHK("enables clear", 8'h80, q)
		acc(1'b0, 4'he, 8'h81);
		@(posedge clk_sys_in) other_flags_set_in <= 7'h01;
		@(posedge clk_sys_in) other_flags_set_in <= 7'h00;
		@(posedge clk_sys_in) #1 `CHK("irq low", 1'b0, interrupt_out_n_out)
		acc(1'b0, 4'hd, 8'h7e);
		acc(1'b1, 4'hd, 8'h00);
		`CHK("flags kept", 8'h81, q)
		acc(1'b0, 4'hd, 8'h7f);
		acc(1'b1, 4'hd, 8'h00);
		`CHK("flags cleared", 8'h00, q)
		`CHK("irq high", 1'b1, interrupt_out_n_out)
		acc(1'b0, 4'he, 8'h84);
		$display("flag test done");
		foreach (rows[k]) begin
			acc(1'b0, 4'h8, rows[k].n);
			acc(1'b0, 4'hb, {3'h0, rows[k].mode, 2'h0});
			peer_set(rows[k].b, !rows[k].mode[2]);
			acc(1'b0, 4'ha, rows[k].b);
			if (rows[k].mode[1:0] == 2'h3) peer_go();
			wait_flag();
			`CHK("shift flag", 8'h84, q & 8'h84)
			`CHK("shift irq", 1'b0, interrupt_out_n_out)
			acc(1'b1, 4'ha, 8'h00);
			if (rows[k].mode[2]) `CHK("sent", rows[k].exp_b, p_rx)
			else `CHK("received", rows[k].exp_b, q)
			acc(1'b1, 4'hd, 8'h00);
			`CHK("flag after access", 8'h00, q)
			acc(1'b0, 4'hb, 8'h00);
			$display("mode %0d test done", rows[k].mode);
		end
		acc(1'b0, 4'h8, 8'h00);
		acc(1'b0, 4'hb, 8'h10);
		peer_set(8'h00, 1'b0);
		acc(1'b0, 4'ha, 8'he7);
		repeat (24) @(posedge serial_clock_pin_in);
		#1 `CHK("repeated byte", 8'he7, p_rx)
		acc(1'b1, 4'hd, 8'h00);
		`CHK("free run flags", 3'h1, {q[2], interrupt_out_n_out})
		acc(1'b0, 4'hb, 8'h00);
		acc(1'b0, 4'hc, 8'hc0);
		@(posedge clk_sys_in) #1 `CHK("off pins", 3'h2, {serial_clock_pin_oe_out, serial_data_pin_oe_out, serial_data_pin_out})
		acc(1'b0, 4'hc, 8'h00);
		$display("free run and off test done");
		acc(1'b0, 4'hb, 8'h0c);
		for (int i = 0; i < 8; i++) begin
			peer_set(8'h10 + 8'(i), 1'b1);
			acc(1'b0, 4'ha, 8'h00);
			peer_go();
			wait_flag();
		end
		acc(1'b0, 4'ha, 8'h00);
		for (int i = 0; i < 8; i++) begin
			acc(1'b1, 4'ha, 8'h00);
			`CHK("buffered byte", 8'h10 + 8'(i), q)
		end
		acc(1'b0, 4'hb, 8'h00);
		$display("buffer test done");
		end_sim();
	end
endmodule
`default_nettype wire
